// ===== hdl/dacs_pkg.sv
// constants for the abstract command status block of a debug module
// assumes a word-addressed debug module interface with 7-bit addresses
package dacs_pkg;

    // debug module interface word addresses
    localparam logic [6:0] ABS_CS_OFF = 7'h16;
    localparam logic [6:0] ABS_CMD_OFF = 7'h17;
    localparam logic [6:0] HALT_SUM_OFF = 7'h40;

    // control/status field positions and fixed values
    localparam int BUSY_BIT = 12;
    localparam int ERR_LSB = 8;
    localparam int ERR_MSB = 10;
    localparam int PROGBUF_LSB = 24;
    localparam int PROGBUF_MSB = 28;
    localparam int DCOUNT_LSB = 0;
    localparam int DCOUNT_MSB = 3;
    localparam logic [3:0] DATA_COUNT = 4'h2;
    localparam logic [4:0] PROGBUF_SIZE = 5'h00;
    localparam int HALT_BIT = 0;

    // command word field positions
    localparam int TYPE_LSB = 24;
    localparam int TYPE_MSB = 31;
    localparam int SIZE_LSB = 20;
    localparam int SIZE_MSB = 22;
    localparam int POSTINC_BIT = 19;
    localparam int POSTEXEC_BIT = 18;
    localparam int REGNO_LSB = 0;
    localparam int REGNO_MSB = 15;
    localparam logic [7:0] TYPE_REG = 8'h00;
    localparam logic [7:0] TYPE_MEM = 8'h02;
    localparam logic [2:0] SIZE_32 = 3'h2;
    localparam logic [15:0] REGNO_LIMIT = 16'h1020;

    // error codes
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_BUSY = 3'h1;
    localparam logic [2:0] ERR_UNSUP = 3'h2;
    localparam logic [2:0] ERR_EXCEPT = 3'h3;
    localparam logic [2:0] ERR_STATE = 3'h4;
    localparam logic [2:0] ERR_OTHER = 3'h7;

    // reset values
    localparam logic [2:0] ERR_RST = 3'h0;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;

    // memory windows reachable by memory access commands (plain defaults)
    localparam logic [31:0] INSTR_BASE = 32'h0000_0000;
    localparam logic [31:0] INSTR_MASK = 32'hFFFF_0000;
    localparam logic [31:0] DATA_BASE = 32'h0001_0000;
    localparam logic [31:0] DATA_MASK = 32'hFFFF_0000;
    localparam logic [31:0] INTC_BASE = 32'h0002_0000;
    localparam logic [31:0] INTC_MASK = 32'hFFFF_0000;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } dacs_state_t;

endpackage

// ===== hdl/dacs_range_hit.sv
// address window compare: hit when the masked address equals the base
// assumes base and mask come from constants
`timescale 1ns/1ps
`default_nettype none
module dacs_range_hit #(
    parameter logic [31:0] BASE = 32'h0000_0000,
    parameter logic [31:0] MASK = 32'hFFFF_0000
) (
    input wire logic [31:0] i_addr,
    output logic o_hit
);

    // one compare per window, no ordering between windows
    assign o_hit = ((i_addr & MASK) == BASE);

endmodule
`default_nettype wire

// ===== hdl/dacs_cmd_check.sv
// combinational check of a command word before it is started
// assumes hart state and target address are steady in the write cycle
`timescale 1ns/1ps
`default_nettype none
module dacs_cmd_check (
    input wire logic [31:0] i_word,
    input wire logic [31:0] i_mem_addr,
    input wire logic i_halted,
    input wire logic i_unavail,
    output logic [2:0] o_err
);

    logic [7:0] kind;
    logic [2:0] size;
    logic [15:0] regno;
    logic hit_instr;
    logic hit_data;
    logic hit_intc;

    assign kind = i_word[dacs_pkg::TYPE_MSB:dacs_pkg::TYPE_LSB];
    assign size = i_word[dacs_pkg::SIZE_MSB:dacs_pkg::SIZE_LSB];
    assign regno = i_word[dacs_pkg::REGNO_MSB:dacs_pkg::REGNO_LSB];

    // windows the memory command may reach
    dacs_range_hit #(
        .BASE(dacs_pkg::INSTR_BASE),
        .MASK(dacs_pkg::INSTR_MASK)
    ) u_instr (
        .i_addr(i_mem_addr),
        .o_hit(hit_instr)
    );
    dacs_range_hit #(
        .BASE(dacs_pkg::DATA_BASE),
        .MASK(dacs_pkg::DATA_MASK)
    ) u_data (
        .i_addr(i_mem_addr),
        .o_hit(hit_data)
    );
    dacs_range_hit #(
        .BASE(dacs_pkg::INTC_BASE),
        .MASK(dacs_pkg::INTC_MASK)
    ) u_intc (
        .i_addr(i_mem_addr),
        .o_hit(hit_intc)
    );

    // unsupported wins over state so it shows whatever the hart does
    always_comb begin
        o_err = dacs_pkg::ERR_NONE;
        if (kind == dacs_pkg::TYPE_REG) begin
            if (i_word[dacs_pkg::POSTINC_BIT] ||
                i_word[dacs_pkg::POSTEXEC_BIT] ||
                regno >= dacs_pkg::REGNO_LIMIT) begin
                o_err = dacs_pkg::ERR_UNSUP;
            end else if (i_unavail || !i_halted) begin
                o_err = dacs_pkg::ERR_STATE;
            end else if (size != dacs_pkg::SIZE_32) begin
                o_err = dacs_pkg::ERR_OTHER;
            end
        end else if (kind == dacs_pkg::TYPE_MEM) begin
            if (i_unavail) begin
                o_err = dacs_pkg::ERR_STATE;
            end else if (size != dacs_pkg::SIZE_32 ||
                         i_mem_addr[1:0] != 2'b00) begin
                o_err = dacs_pkg::ERR_OTHER;
            end else if (!(hit_instr || hit_data || hit_intc)) begin
                o_err = dacs_pkg::ERR_EXCEPT;
            end
        end else begin
            o_err = dacs_pkg::ERR_UNSUP;
        end
    end

endmodule
`default_nettype wire

// ===== hdl/dacs_abstract_cs.sv
// abstract command status and control for a single-hart debug module
// assumes debugger accesses arrive as one-cycle strobes on i_clk_sys
// and that the hart side runs on the same clock
//
// How it works
// - halt summary bit 0 is the halted state, bits 31:1 read zero.
// - an unavailable hart never shows as halted in the summary.
// - a control or command write, or data access while busy sets code 1 if 0, unless the hart reports an error that cycle.
// - busy goes high when a command starts and low when it is done.
// - code 0 means no error, 2 unsupported, 3 address outside windows.
// - code 4 wrong hart state, 7 bad size or alignment; a hart's done error is stored as is.
// - the code stays until cleared by writing ones to its bits.
// - a nonzero code makes command writes ignored and starts nothing.
// - the data count field reads as two and cannot be written.
// - the program buffer size field reads zero and cannot be written.
// - an accepted command write that passes the checks executes the written command.
// - memory commands only reach the three local windows.
// - type 0 is register access, 2 memory access, others unsupported.
`timescale 1ns/1ps
`default_nettype none
module dacs_abstract_cs (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // debugger side, word addressed
    input wire logic [6:0] i_dmi_addr,
    input wire logic [31:0] i_dmi_wdata,
    input wire logic i_dmi_wr,
    input wire logic i_dmi_rd,
    output logic [31:0] o_dmi_rdata,
    // any read or write of either argument word
    input wire logic i_arg_access,
    // hart side
    input wire logic i_hart_halted,
    input wire logic i_hart_unavail,
    input wire logic [31:0] i_mem_addr,
    output logic o_cmd_start,
    output logic [31:0] o_cmd_word,
    input wire logic i_cmd_done,
    input wire logic [2:0] i_cmd_err,
    output logic o_busy
);

    dacs_pkg::dacs_state_t state_q;
    dacs_pkg::dacs_state_t state_d;
    logic [2:0] err_q;
    logic [2:0] err_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic start_q;
    logic [31:0] word_q;
    logic wr_cs;
    logic wr_cmd;
    logic busy;
    logic busy_hit;
    logic accept;
    logic start;
    logic [2:0] chk_err;
    logic [2:0] set_code;
    logic [2:0] clr_bits;
    logic set_ev;
    logic halted_vis;
    logic [31:0] cs_word;
    logic [31:0] sum_word;

    // address decode of the two writable locations
    assign wr_cs = i_dmi_wr && (i_dmi_addr == dacs_pkg::ABS_CS_OFF);
    assign wr_cmd = i_dmi_wr && (i_dmi_addr == dacs_pkg::ABS_CMD_OFF);

    assign busy = (state_q == dacs_pkg::ST_EXEC);

    // a control or command write or argument access that collides with a running command
    assign busy_hit = busy &&
                      (wr_cs || wr_cmd || i_arg_access);

    // only an idle block with a clean code looks at a command write
    assign accept = wr_cmd && !busy &&
                    (err_q == dacs_pkg::ERR_NONE);

    // checks run in the write cycle against the hart's present state
    dacs_cmd_check u_check (
        .i_word(i_dmi_wdata),
        .i_mem_addr(i_mem_addr),
        .i_halted(i_hart_halted),
        .i_unavail(i_hart_unavail),
        .o_err(chk_err)
    );

    assign start = accept && (chk_err == dacs_pkg::ERR_NONE);

    // pick the one error event of this cycle; first failure is kept
    always_comb begin
        set_ev = 1'b0;
        set_code = dacs_pkg::ERR_NONE;
        if (busy && i_cmd_done &&
            i_cmd_err != dacs_pkg::ERR_NONE) begin
            set_ev = 1'b1;
            set_code = i_cmd_err;
        end else if (busy_hit) begin
            set_ev = 1'b1;
            set_code = dacs_pkg::ERR_BUSY;
        end else if (accept && chk_err != dacs_pkg::ERR_NONE) begin
            set_ev = 1'b1;
            set_code = chk_err;
        end
    end

    assign clr_bits = i_dmi_wdata[dacs_pkg::ERR_MSB:dacs_pkg::ERR_LSB];

    // error code: clear by ones written, a set in the same cycle wins only if the code is zero after the clear;
    // a full clear together with a new event must not lose the event
    always_comb begin
        err_d = err_q;
        if (wr_cs) begin
            err_d = err_q & ~clr_bits;
        end
        if (set_ev && err_d == dacs_pkg::ERR_NONE) begin
            err_d = set_code;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            err_q <= dacs_pkg::ERR_RST;
        end else begin
            err_q <= err_d;
        end
    end

    // command state: busy from start until the hart reports done
    always_comb begin
        state_d = state_q;
        case (state_q)
            dacs_pkg::ST_IDLE: begin
                if (start) begin
                    state_d = dacs_pkg::ST_EXEC;
                end
            end
            dacs_pkg::ST_EXEC: begin
                if (i_cmd_done) begin
                    state_d = dacs_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = dacs_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= dacs_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // start pulse and the command word handed to the hart
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            start_q <= 1'b0;
        end else begin
            start_q <= start;
        end
    end

    // word is held for the whole command; ignored writes leave it
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            word_q <= dacs_pkg::WORD_RST;
        end else if (start) begin
            word_q <= i_dmi_wdata;
        end
    end

    // an unavailable hart is never reported halted
    assign halted_vis = i_hart_halted && !i_hart_unavail;

    // halt summary image, upper bits fixed at zero
    always_comb begin
        sum_word = dacs_pkg::WORD_RST;
        sum_word[dacs_pkg::HALT_BIT] = halted_vis;
    end

    // control/status image; reserved and fixed fields not writable
    always_comb begin
        cs_word = dacs_pkg::WORD_RST;
        cs_word[dacs_pkg::BUSY_BIT] = busy;
        cs_word[dacs_pkg::ERR_MSB:dacs_pkg::ERR_LSB] = err_q;
        cs_word[dacs_pkg::PROGBUF_MSB:dacs_pkg::PROGBUF_LSB] =
            dacs_pkg::PROGBUF_SIZE;
        cs_word[dacs_pkg::DCOUNT_MSB:dacs_pkg::DCOUNT_LSB] =
            dacs_pkg::DATA_COUNT;
    end

    // read mux; command location is write only and reads zero
    always_comb begin
        rdata_d = dacs_pkg::WORD_RST;
        case (i_dmi_addr)
            dacs_pkg::ABS_CS_OFF: begin
                rdata_d = cs_word;
            end
            dacs_pkg::HALT_SUM_OFF: begin
                rdata_d = sum_word;
            end
            default: begin
                rdata_d = dacs_pkg::WORD_RST;
            end
        endcase
    end

    // read data is captured on the strobe and held until the next read
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= dacs_pkg::WORD_RST;
        end else if (i_dmi_rd) begin
            rdata_q <= rdata_d;
        end
    end

    // outputs
    assign o_dmi_rdata = rdata_q;
    assign o_cmd_start = start_q;
    assign o_cmd_word = word_q;
    assign o_busy = busy; // flop-backed state, safe for the hart to watch

endmodule
`default_nettype wire

// ===== verification/dacs_abstract_cs_monitor.sv
// concurrent checks on the abstract command status ports
// assumes it is bound into dacs_abstract_cs, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dacs_abstract_cs_monitor (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [6:0] i_dmi_addr,
    input wire logic [31:0] i_dmi_wdata,
    input wire logic i_dmi_wr,
    input wire logic i_dmi_rd,
    input wire logic [31:0] o_dmi_rdata,
    input wire logic i_hart_halted,
    input wire logic i_hart_unavail,
    input wire logic o_cmd_start,
    input wire logic [31:0] o_cmd_word,
    input wire logic i_cmd_done,
    input wire logic o_busy
);
    logic halt_vis;
    logic cmd_wr_idle;
    logic cs_rd;
    // causes kept as nets so that $past sees plain signals
    assign halt_vis = i_hart_halted & ~i_hart_unavail;
    assign cmd_wr_idle = i_dmi_wr && !o_busy
        && i_dmi_addr == dacs_pkg::ABS_CMD_OFF;
    assign cs_rd = i_dmi_rd && i_dmi_addr == dacs_pkg::ABS_CS_OFF;
    // all checks share the system clock and its reset
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    a_busy_rise_start: assert property (
        $rose(o_busy) |-> o_cmd_start)
        else $error("busy rose without a start");
    a_busy_done_drop: assert property (
        o_busy && i_cmd_done |=> !o_busy)
        else $error("busy held after done");
    a_start_cause: assert property (
        o_cmd_start |-> $past(cmd_wr_idle))
        else $error("start without idle command write");
    a_start_word: assert property (
        o_cmd_start |-> o_cmd_word == $past(i_dmi_wdata))
        else $error("command word differs from write");
    a_word_hold: assert property (
        !o_cmd_start |-> $stable(o_cmd_word))
        else $error("command word moved without start");
    a_halt_read: assert property (
        i_dmi_rd && i_dmi_addr == dacs_pkg::HALT_SUM_OFF |=>
        o_dmi_rdata == {31'h0000_0000, $past(halt_vis)})
        else $error("halt summary wrong");
    a_cs_fixed: assert property (
        cs_rd |=> o_dmi_rdata[12] == $past(o_busy) &&
        {o_dmi_rdata[31:13], o_dmi_rdata[11], o_dmi_rdata[7:0]} ==
        28'h000_0002)
        else $error("control status fixed fields wrong");
    a_unmapped_zero: assert property (
        i_dmi_rd && !cs_rd && i_dmi_addr != dacs_pkg::HALT_SUM_OFF |=>
        o_dmi_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ===== verification/dacs_hart_model.sv
// behavioural hart answering started commands after a chosen delay
// assumes start is a one-cycle pulse on the system clock
`timescale 1ns/1ps
`default_nettype none
module dacs_hart_model (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [3:0] i_delay,
    input wire logic [2:0] i_err,
    output logic o_done,
    output logic [2:0] o_err
);
    logic [3:0] cnt_q;
    // countdown; zero delay answers in the start cycle itself
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) cnt_q <= 4'h0;
        else if (i_start) cnt_q <= i_delay;
        else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    end
    // error code is junk outside done, as a real hart gives no promise
    assign o_done = (i_start && i_delay == 4'h0) || cnt_q == 4'h1;
    assign o_err = o_done ? i_err : 3'h5;
endmodule
`default_nettype wire

// ===== verification/dacs_abstract_cs_tb_top.sv
// self-checking bench for the abstract command status block
// assumes the hart model finishes commands after a random delay
`timescale 1ns/1ps
`default_nettype none
module dacs_abstract_cs_tb_top;
    logic clk, rst_n, wr, rd, arg, halted, unavail, start, done, busy, rd_seen;
    logic [6:0] addr;
    logic [31:0] wdata, rdata, maddr, word, r, last_w;
    logic [2:0] herr, derr;
    logic [3:0] dly;
    logic [31:0] exp_q[$];
    int n_fail, tests_run, cyc, n_start;
    logic [31:0] tw [15] = '{32'h0022_1000, 32'h0500_0000, 32'h0022_1020,
        32'h002A_1000, 32'h0026_1000, 32'h0022_1000, 32'h0022_1000,
        32'h0012_1000, 32'h0222_0000, 32'h0222_0000, 32'h0222_0000,
        32'h0202_0000, 32'h0222_0000, 32'h0222_0000, 32'h0222_0000};
    logic [31:0] ta [15] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0003_0000, 32'h0001_0002, 32'h0001_0000,
        32'h0001_0000, 32'h0002_0000, 32'h0001_0000, 32'h0};
    // halted, unavailable, expected code
    logic [4:0] te [15] = '{5'h10, 5'h12, 5'h12, 5'h12, 5'h12, 5'h04,
        5'h1C, 5'h17, 5'h03, 5'h07, 5'h0C, 5'h07, 5'h00, 5'h10, 5'h10};
    localparam logic [6:0] CS = dacs_pkg::ABS_CS_OFF;
    localparam logic [6:0] CMD = dacs_pkg::ABS_CMD_OFF;

    dacs_abstract_cs uut (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_dmi_addr(addr), .i_dmi_wdata(wdata), .i_dmi_wr(wr),
        .i_dmi_rd(rd), .o_dmi_rdata(rdata), .i_arg_access(arg),
        .i_hart_halted(halted), .i_hart_unavail(unavail),
        .i_mem_addr(maddr), .o_cmd_start(start), .o_cmd_word(word),
        .i_cmd_done(done), .i_cmd_err(derr), .o_busy(busy));
    dacs_hart_model hart (.i_clk_sys(clk), .i_rst_n(rst_n), .i_start(start),
        .i_delay(dly), .i_err(herr), .o_done(done), .o_err(derr));

    // free-running clock, 25 ns period
    always #12.5 clk = ~clk;

    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [31:0] cs(input logic b, input logic [2:0] e);
        return {19'h0_0000, b, 1'b0, e, 8'h02};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want) begin
            n_fail++;
            $display("ERROR %0t: got %h want %h", $time, got, want);
        end
    endtask
    // one access, then an idle edge so strobes never double up
    task automatic acc(input logic rr, input logic ww, input logic [6:0] a,
            input logic [31:0] d);
        rd <= rr;
        wr <= ww;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_exp(input logic [6:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        acc(1'b1, 1'b0, a, 32'h0);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge clk);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // read data is due one cycle after the strobe; oldest note first
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) begin
        if (rd_seen) chk(rdata, exp_q.pop_front());
        if (start === 1'b1) n_start++;
    end
    // hang guard well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            results();
        end
    end

    initial begin
        int n0;
        {clk, rst_n, wr, rd, arg, halted, unavail} = 7'h00;
        {addr, wdata, maddr, herr, dly, last_w} = '0;
        r = 32'h4f15_1b1d;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_exp(CS, cs(1'b0, 3'h0));
        rd_exp(CMD, 32'h0);
        rd_exp(7'h11, 32'h0);
        acc(1'b0, 1'b1, CS, 32'hFFFF_F8FF);
        rd_exp(CS, cs(1'b0, 3'h0));
        for (int i = 0; i < 4; i++) begin
            {halted, unavail} <= i[1:0];
            rd_exp(dacs_pkg::HALT_SUM_OFF, {31'h0, i == 2});
        end
        $display("test fixed fields done");
        for (int i = 0; i < 15; i++) begin
            r = nxt(r);
            {halted, unavail} <= te[i][4:3];
            maddr <= ta[i] | {16'h0000, r[15:2], 2'b00};
            dly <= r[19:16];
            n0 = n_start;
            acc(1'b0, 1'b1, CMD, tw[i]);
            wait_idle();
            if (te[i][2:0] == 3'h0) last_w = tw[i];
            chk(32'(n_start - n0),
                {31'h0, te[i][2:0] == 3'h0});
            chk(word, last_w);
            rd_exp(CS, cs(1'b0, te[i][2:0]));
            acc(1'b0, 1'b1, CS, 32'h0000_0700);
        end
        $display("test command checks done");
        {halted, unavail} <= 2'b10;
        herr <= 3'h3;
        dly <= 4'h8;
        acc(1'b0, 1'b1, CMD, 32'h0022_1001);
        rd_exp(CS, cs(1'b1, 3'h0));
        arg <= 1'b1;
        @(posedge clk);
        arg <= 1'b0;
        wait_idle();
        rd_exp(CS, cs(1'b0, 3'h1));
        acc(1'b0, 1'b1, CS, 32'h0000_0700);
        acc(1'b0, 1'b1, CMD, 32'h0022_1002);
        wait_idle();
        rd_exp(CS, cs(1'b0, 3'h3));
        acc(1'b0, 1'b1, CS, 32'h0000_0100);
        rd_exp(CS, cs(1'b0, 3'h2));
        n0 = n_start;
        acc(1'b0, 1'b1, CMD, 32'h0022_1000);
        chk(32'(n_start - n0), 32'h0);
        acc(1'b0, 1'b1, CS, 32'h0000_0600);
        herr <= 3'h0;
        acc(1'b0, 1'b1, CMD, 32'h0022_1003);
        acc(1'b0, 1'b1, CMD, 32'h0022_1004);
        wait_idle();
        chk(32'(n_start - n0), 32'h1);
        rd_exp(CS, cs(1'b0, 3'h1));
        // a control/status write while busy must flag a collision too
        acc(1'b0, 1'b1, CS, 32'h0000_0700);
        acc(1'b0, 1'b1, CMD, 32'h0022_1005);
        acc(1'b0, 1'b1, CS, 32'h0000_0000);
        wait_idle();
        rd_exp(CS, cs(1'b0, 3'h1));
        $display("test busy and error flow done");
        results();
    end
endmodule
bind dacs_abstract_cs dacs_abstract_cs_monitor mon (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .i_dmi_addr(i_dmi_addr), .i_dmi_wdata(i_dmi_wdata),
    .i_dmi_wr(i_dmi_wr), .i_dmi_rd(i_dmi_rd), .o_dmi_rdata(o_dmi_rdata),
    .i_hart_halted(i_hart_halted), .i_hart_unavail(i_hart_unavail),
    .o_cmd_start(o_cmd_start), .o_cmd_word(o_cmd_word),
    .i_cmd_done(i_cmd_done), .o_busy(o_busy));
`default_nettype wire
